// ==== verif/counter8_asserts.sv ====
// Port checks of the 8-bit counter
`timescale 1ns/10ps
`default_nettype none
module counter8_asserts (
	input wire logic       mclk,                // clk
	input wire logic       srst,                // rst
	input wire logic [2:0] reg_addr,            // bus
	input wire logic [7:0] reg_wdata,           // bus
	input wire logic       reg_wr,              // bus
	input wire logic       reg_rd,              // bus
	input wire logic [7:0] reg_rdata,           // bus
	input wire logic       ext_count_input,     // pin
	input wire logic       sleep_mode,          // core
	input wire logic       watchdog_clear_instr, // wdt
	input wire logic       watchdog_tick,       // wdt
	input wire logic       watchdog_presc_tick, // wdt
	input wire logic       port_pullup_disable, // opt
	input wire logic       ext_int_edge,        // opt
	input wire logic       irq                  // irq
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	logic [7:0] opt_reg;
	always_ff @(posedge mclk)
		if (srst) opt_reg <= 8'hff;
		else if (reg_wr && reg_addr == 3'h0) opt_reg <= reg_wdata;
	chk_pullup_follow: assert property ($stable(opt_reg) [*2] |->
		port_pullup_disable == opt_reg[7]) else $error("pull-up level wrong");
	chk_edge_follow: assert property ($stable(opt_reg) [*2] |->
		ext_int_edge == opt_reg[6]) else $error("edge select wrong");
	chk_wdt_owner: assert property (!opt_reg[3] && !$past(opt_reg[3]) |->
		!watchdog_presc_tick) else $error("wdt tick while counter owns");
	chk_wdt_undivided: assert property (opt_reg[3] && opt_reg[2:0] == 3'h0 &&
		watchdog_tick && !sleep_mode && !watchdog_clear_instr |=> watchdog_presc_tick)
		else $error("wdt tick lost");
	chk_wdt_cause: assert property (watchdog_presc_tick |-> $past(watchdog_tick))
		else $error("wdt tick without cause");
	chk_irq_mask: assert property (reg_wr && reg_addr == 3'h5 && !reg_wdata[0] |->
		##[1:2] !irq) else $error("irq not masked");
	chk_irq_sticky: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("irq cleared by hardware");
	chk_sleep_frozen: assert property ((sleep_mode && !reg_wr) [*3] |=> !$rose(irq))
		else $error("irq in sleep");
endmodule : counter8_asserts
bind counter8_shared_prescaler counter8_asserts chk (.mclk, .srst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .ext_count_input, .sleep_mode, .watchdog_clear_instr,
	.watchdog_tick, .watchdog_presc_tick, .port_pullup_disable, .ext_int_edge, .irq);
`default_nettype wire

// ==== verif/counter8_shared_prescaler_tb_top.sv ====
// Self-checking bench of the 8-bit counter
`timescale 1ns/10ps
`default_nettype none
module counter8_shared_prescaler_tb_top;
	logic       mclk = 1'b0;
	logic       srst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       sleep_mode = 1'b0;
	logic       watchdog_clear_instr = 1'b0;
	logic       watchdog_tick = 1'b0;
	logic [3:0] n = 4'h0;
	logic [7:0] reg_rdata, rv, sv;
	logic       ext_count_input, watchdog_presc_tick, port_pullup_disable, ext_int_edge, irq;
	int         err_total = 0;
	int         total_checks = 0;
	// Write address, data, read address, expected
	logic [7:0] rows [6][4] = '{'{8'h0, 8'h28, 8'h0, 8'h28}, '{8'h1, 8'h5a, 8'h1, 8'h5a},
		'{8'h2, 8'hff, 8'h2, 8'h24}, '{8'h4, 8'h01, 8'h3, 8'h00},
		'{8'h3, 8'hff, 8'h5, 8'h01}, '{8'h6, 8'hff, 8'h6, 8'h00}};
	counter8_shared_prescaler dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ext_count_input, .sleep_mode, .watchdog_clear_instr, .watchdog_tick,
		.watchdog_presc_tick, .port_pullup_disable, .ext_int_edge, .irq);
	pin_src src (.mclk, .n, .pin(ext_count_input));
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk) watchdog_tick <= ~watchdog_tick;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		@(posedge mclk);
	endtask : rd
	task automatic clr;
		watchdog_clear_instr <= 1'b1;
		@(posedge mclk);
		watchdog_clear_instr <= 1'b0;
	endtask : clr
	task automatic toggle(input logic [3:0] k);
		// Let the post-write hold-off run out before the first pin edge
		repeat (12) @(posedge mclk);
		n <= k;
		@(posedge mclk);
		n <= 4'h0;
		repeat (100) @(posedge mclk);
	endtask : toggle
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5000) @(posedge mclk);
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rd(3'h0);
		chk(rv, 8'hff);
		chk({5'h0, port_pullup_disable, ext_int_edge, irq}, 8'h06);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i][0][2:0], rows[i][1]);
			rd(rows[i][2][2:0]);
			chk(rv, rows[i][3]);
		end
		chk({6'h0, port_pullup_disable, ext_int_edge}, 8'h00);
		$display("register test done");
		wr(3'h1, 8'hfd);
		toggle(4'h6);
		rd(3'h1);
		chk(rv, 8'h00);
		chk({7'h0, irq}, 8'h01);
		wr(3'h5, 8'h00);
		rd(3'h3);
		chk({rv[0], irq}, 2'h2);
		$display("overflow test done");
		clr;
		wr(3'h0, 8'h20);
		wr(3'h1, 8'h00);
		toggle(4'h8);
		rd(3'h1);
		chk(rv, 8'h02);
		toggle(4'h2);
		wr(3'h1, 8'h00);
		toggle(4'h2);
		rd(3'h1);
		chk(rv, 8'h00);
		$display("prescaler test done");
		clr;
		wr(3'h1, 8'h00);
		clr;
		wr(3'h0, 8'h28);
		clr;
		wr(3'h0, 8'h38);
		toggle(4'h1);
		rd(3'h1);
		chk(rv, 8'h00);
		toggle(4'h1);
		rd(3'h1);
		chk(rv, 8'h01);
		$display("edge test done");
		wr(3'h0, 8'h08);
		clr;
		wr(3'h1, 8'h00);
		repeat (37) @(posedge mclk);
		rd(3'h1);
		chk({7'h0, rv > 8'h05 && rv < 8'h09}, 8'h01);
		sleep_mode <= 1'b1;
		rd(3'h1);
		sv = rv;
		repeat (40) @(posedge mclk);
		rd(3'h1);
		chk(rv, sv);
		sleep_mode <= 1'b0;
		$display("timer test done");
		srst <= 1'b1;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rd(3'h0);
		chk(rv, 8'hff);
		rd(3'h2);
		chk(rv, 8'h00);
		chk({6'h0, port_pullup_disable, ext_int_edge}, 8'h03);
		$display("reset test done");
		end_of_test;
	end
endmodule : counter8_shared_prescaler_tb_top
`default_nettype wire

// ==== verif/pin_src.sv ====
// Count pin source: makes a number of slow toggles
`timescale 1ns/10ps
`default_nettype none
module pin_src (
	input  wire logic       mclk, // clk
	input  wire logic [3:0] n,    // toggles, taken when idle
	output logic            pin   // pin
);
	logic [3:0] left = 4'h0;
	logic [2:0] t = 3'h0;
	initial pin = 1'b0;
	// Each level holds 8 clocks, over the filter minimum
	always @(posedge mclk) begin
		t <= t + 3'h1;
		if (left == 4'h0) left <= n;
		else if (t == 3'h0) begin
			pin <= ~pin;
			left <= left - 4'h1;
		end
	end
endmodule : pin_src
`default_nettype wire

// ==== verilog/counter8_params.svh ====
// Offsets, field positions, reset values and timing counts of the 8-bit counter
`ifndef COUNTER8_PARAMS_SVH
`define COUNTER8_PARAMS_SVH

`define CNT_ADDR_W           3
`define CNT_OFS_OPTION       3'h0
`define CNT_OFS_COUNT        3'h1
`define CNT_OFS_IRQ_CONTROL  3'h2
`define CNT_OFS_IRQ_STATUS   3'h3
`define CNT_OFS_IRQ_CLEAR    3'h4
`define CNT_OFS_IRQ_ENABLE   3'h5

`define CNT_OPT_PULLUP_DIS   7
`define CNT_OPT_INT_EDGE     6
`define CNT_OPT_SRC_SEL      5
`define CNT_OPT_SRC_EDGE     4
`define CNT_OPT_PSA          3
`define CNT_OPT_RATE_HI      2
`define CNT_OPT_RATE_LO      0

`define CNT_IRQC_OVF_EN      5
`define CNT_IRQC_OVF_FLAG    2
`define CNT_IRQ_OVF_BIT      0

`define CNT_OPTION_RESET     8'hff
`define CNT_COUNT_RESET      8'h00
`define CNT_COUNT_MAX        8'hff

`define CNT_PHASE_Q2         2'h1
`define CNT_PHASE_Q4         2'h3
`define CNT_CLK_PER_INSTR    4
`define CNT_INHIBIT_INSTR    2
`define CNT_INHIBIT_CLKS     (`CNT_INHIBIT_INSTR * `CNT_CLK_PER_INSTR)

`endif

// ==== verilog/counter8_pkg.sv ====
// Types of the 8-bit counter with shared prescaler
package counter8_pkg;

	typedef struct packed {
		logic [7:0] option;     // Option register
		logic [7:0] count;      // 8-bit count
		logic [7:0] presc;      // Shared prescaler count
		logic       ovf_flag;   // Sticky overflow flag
		logic       ovf_en;     // Overflow interrupt enable
		logic [1:0] phase;      // Q1..Q4 phase within an instruction cycle
		logic [3:0] inhibit;    // Increment hold-off after a count write
		logic       pend;       // Increment waiting for a Q2/Q4 sample
		logic       sync1;      // Pin synchroniser stages
		logic       sync2;
		logic       sync3;
		logic       pin_lvl;    // Filtered pin level
		logic [7:0] rdata;      // Read data
		logic       irq;        // Interrupt output
		logic       wdt_out;    // Prescaled watchdog tick
	} state_t;

endpackage : counter8_pkg

// ==== verilog/counter8_shared_prescaler.sv ====
// 8-bit timer/counter with a prescaler shared with the watchdog
// Functional notes
// - One prescaler serves either the counter or the watchdog, never both.
// - Option bit 3 high gives the prescaler to the watchdog, low to counter.
// - Counter rate codes 000..111 divide by 2 up to 256, doubling.
// - Watchdog rate codes 000..111 divide by 1 up to 128, doubling.
// - Counter counts undivided only while the prescaler belongs to the watchdog.
// - Prescaler not accessible; count writes clear it while owned by counter.
// - Watchdog clear instruction clears the prescaler while owned by watchdog.
// - Overflow flag sets on every wrap from ff to 00, enabled or not.
// - Only software clears the flag; interrupt raised only while enabled.
// - Counter is frozen in sleep, so overflow never wakes the processor.
// - External increments are synchronised by sampling on Q2 and Q4.
// - Option bit 5 selects pin transitions (1) or instruction clock (0).
// - Option bit 4 high counts falling pin edges, low counts rising edges.
// - Option bit 7 high disables port pull-ups; low enables them per latch.
// - Option bit 6 high selects rising external interrupt edge, low falling.
// - With option bit 5 low and bit 3 high, count increments each instruction cycle; writes inhibit two cycles.
`include "counter8_params.svh"
`timescale 1ns/10ps
`default_nettype none

module counter8_shared_prescaler (
	input  wire logic                   mclk,                 // 20 MHz oscillator clock
	input  wire logic                   srst,                 // Synchronous reset, high
	input  wire logic [`CNT_ADDR_W-1:0] reg_addr,             // Register address
	input  wire logic [7:0]             reg_wdata,            // Write data
	input  wire logic                   reg_wr,               // Write strobe
	input  wire logic                   reg_rd,               // Read strobe
	output logic      [7:0]             reg_rdata,            // Read data, cycle after strobe
	input  wire logic                   ext_count_input,      // External count pin
	input  wire logic                   sleep_mode,           // Core is in sleep
	input  wire logic                   watchdog_clear_instr, // Watchdog clear pulse
	input  wire logic                   watchdog_tick,        // Watchdog base tick pulse
	output logic                        watchdog_presc_tick,  // Prescaled watchdog tick
	output logic                        port_pullup_disable,  // Port pull-up disable level
	output logic                        ext_int_edge,         // Ext interrupt edge select
	output logic                        irq                   // Overflow interrupt level
);

	counter8_pkg::state_t s_reg;
	counter8_pkg::state_t s_next;

	// True when the low nbits of v are all ones; nbits of zero is always true
	function automatic logic presc_term(input logic [7:0] v, input logic [3:0] nbits);
		logic [8:0] m;
		m = (9'h001 << nbits) - 9'h001;
		return (v & m[7:0]) == m[7:0];
	endfunction : presc_term

	logic       prescaler_assign;
	logic [2:0] rate;
	logic       pin_edge;
	logic       src_tick;
	logic       inc_req;
	logic       sample;
	logic       ovf_set;
	logic       wr_count;

	always_comb begin
		s_next   = s_reg;
		prescaler_assign      = s_reg.option[`CNT_OPT_PSA];
		rate     = s_reg.option[`CNT_OPT_RATE_HI:`CNT_OPT_RATE_LO];
		inc_req  = 1'b0;
		ovf_set  = 1'b0;
		wr_count = reg_wr && (reg_addr == `CNT_OFS_COUNT);

		// Three-stage pin synchroniser, level accepted once stages two and three agree
		s_next.sync1 = ext_count_input;
		s_next.sync2 = s_reg.sync1;
		s_next.sync3 = s_reg.sync2;
		if (s_reg.sync2 == s_reg.sync3) begin
			s_next.pin_lvl = s_reg.sync3;
		end
		pin_edge = (s_next.pin_lvl != s_reg.pin_lvl) &&
			(s_next.pin_lvl != s_reg.option[`CNT_OPT_SRC_EDGE]);

		s_next.phase = s_reg.phase + 2'h1;
		src_tick = s_reg.option[`CNT_OPT_SRC_SEL] ? pin_edge :
			(s_reg.phase == `CNT_PHASE_Q4);
		sample = (s_reg.phase == `CNT_PHASE_Q2) || (s_reg.phase == `CNT_PHASE_Q4);

		s_next.wdt_out = 1'b0;
		if (s_reg.inhibit != 4'h0) begin
			s_next.inhibit = s_reg.inhibit - 4'h1;
		end

		if (!sleep_mode) begin
			if (!prescaler_assign) begin
				if (src_tick) begin
					s_next.presc = s_reg.presc + 8'h01;
					inc_req = presc_term(s_reg.presc, {1'b0, rate} + 4'h1);
				end
			end else begin
				inc_req = src_tick;
				if (watchdog_tick) begin
					s_next.presc   = s_reg.presc + 8'h01;
					s_next.wdt_out = presc_term(s_reg.presc, {1'b0, rate});
				end
			end
			if (inc_req) begin
				s_next.pend = 1'b1;
			end
			if (sample) begin
				// A request arriving on a sample cycle stays pending for the next one
				s_next.pend = inc_req;
				if (s_reg.pend && s_reg.inhibit == 4'h0) begin
					s_next.count = s_reg.count + 8'h01;
					ovf_set = (s_reg.count == `CNT_COUNT_MAX);
				end
			end
		end

		if (prescaler_assign && watchdog_clear_instr) begin
			s_next.presc = 8'h00;
		end

		if (ovf_set) begin
			s_next.ovf_flag = 1'b1;
		end

		if (reg_wr) begin
			case (reg_addr)
				`CNT_OFS_OPTION: begin
					s_next.option = reg_wdata;
				end
				`CNT_OFS_COUNT: begin
					s_next.count   = reg_wdata;
					s_next.inhibit = 4'(`CNT_INHIBIT_CLKS);
					s_next.pend    = 1'b0;
				end
				`CNT_OFS_IRQ_CONTROL: begin
					s_next.ovf_en   = reg_wdata[`CNT_IRQC_OVF_EN];
					s_next.ovf_flag = reg_wdata[`CNT_IRQC_OVF_FLAG] | ovf_set;
				end
				`CNT_OFS_IRQ_CLEAR: begin
					if (reg_wdata[`CNT_IRQ_OVF_BIT] && !ovf_set) begin
						s_next.ovf_flag = 1'b0;
					end
				end
				`CNT_OFS_IRQ_ENABLE: begin
					s_next.ovf_en = reg_wdata[`CNT_IRQ_OVF_BIT];
				end
				default: begin
				end
			endcase
		end

		if (wr_count && !prescaler_assign) begin
			s_next.presc = 8'h00;
		end

		s_next.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`CNT_OFS_OPTION: begin
					s_next.rdata = s_reg.option;
				end
				`CNT_OFS_COUNT: begin
					s_next.rdata = s_reg.count;
				end
				`CNT_OFS_IRQ_CONTROL: begin
					s_next.rdata[`CNT_IRQC_OVF_EN]   = s_reg.ovf_en;
					s_next.rdata[`CNT_IRQC_OVF_FLAG] = s_reg.ovf_flag;
				end
				`CNT_OFS_IRQ_STATUS: begin
					s_next.rdata[`CNT_IRQ_OVF_BIT] = s_reg.ovf_flag;
				end
				`CNT_OFS_IRQ_ENABLE: begin
					s_next.rdata[`CNT_IRQ_OVF_BIT] = s_reg.ovf_en;
				end
				default: begin
				end
			endcase
		end

		s_next.irq = s_next.ovf_flag && s_next.ovf_en;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_reg          <= '0;
			s_reg.option   <= `CNT_OPTION_RESET;
			s_reg.count    <= `CNT_COUNT_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata           = s_reg.rdata;
	assign watchdog_presc_tick = s_reg.wdt_out;
	assign port_pullup_disable = s_reg.option[`CNT_OPT_PULLUP_DIS];
	assign ext_int_edge        = s_reg.option[`CNT_OPT_INT_EDGE];
	assign irq                 = s_reg.irq;

endmodule : counter8_shared_prescaler

`default_nettype wire
